/* gw_pkg.sv */
// Constants and types shared by the serial-to-CAN message gateway
package gw_pkg;
   // Request function codes
   localparam logic [7:0]  FN_RD_HOLD   = 8'h03;
   localparam logic [7:0]  FN_RD_INPUT  = 8'h04;
   localparam logic [7:0]  FN_WR_SINGLE = 8'h06;
   localparam logic [7:0]  FN_WR_MULTI  = 8'h10;
   // Frame layout in registers
   localparam int          FRAME_WORDS  = 9;
   localparam logic [3:0]  FRAME_LAST   = 4'h8;
   localparam int          TX_WORDS     = 7;
   localparam logic [15:0] TX_QTY       = 16'h0007;
   localparam logic [7:0]  TX_BYTE_CNT  = 8'h0D;
   localparam logic [15:0] TX_LAST_REG  = 16'h0006;
   localparam logic [7:0]  HOLD_BYTES   = 8'h0E;
   localparam logic [15:0] MAX_RD_QTY   = 16'h007D;
   // Request buffer and queue sizes
   localparam int          RX_BUF_BYTES = 24;
   localparam logic [4:0]  RX_BUF_LAST  = 5'h17;
   localparam logic [4:0]  LEN_SHORT    = 5'h08;
   localparam logic [4:0]  LEN_MULTI    = 5'h17;
   localparam logic [7:0]  ECHO_LEN     = 8'h06;
   localparam logic [7:0]  READ_HDR_LEN = 8'h03;
   localparam int          QUEUE_DEPTH  = 8;
   localparam logic [3:0]  QUEUE_FULL   = 4'h8;
   // Checksum
   localparam logic [15:0] CRC_INIT     = 16'hFFFF;
   localparam logic [15:0] CRC_POLY     = 16'hA001;
   localparam logic [15:0] ZERO_WORD    = 16'h0000;
   // Controller states
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_CHECK  = 5'b00010,
      ST_SEND   = 5'b00100,
      ST_CRC_LO = 5'b01000,
      ST_CRC_HI = 5'b10000
   } state_t;
endpackage : gw_pkg

/* modbus_can_gateway.sv */
// Serial request handler, CAN receive queue and CAN transmit record
`timescale 1ns/1ps
module modbus_can_gateway (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Configuration
   input  wire logic         slaveMode,
   input  wire logic [7:0]   nodeId,
   // Serial receive bytes
   input  wire logic [7:0]   rxByte,
   input  wire logic         rxValid,
   input  wire logic         rxEnd,
   // Serial transmit bytes
   output logic      [7:0]   txByte,
   output logic              txValid,
   input  wire logic         txReady,
   // CAN receive side
   input  wire logic [143:0] canRxData,
   input  wire logic         canRxValid,
   input  wire logic         canRxSpecific,
   output logic              queueDrop,
   // CAN transmit side
   output logic      [111:0] canTxFrame,
   output logic              canTxPending,
   output logic              canTxStart,
   input  wire logic         canBusIdle
);
   gw_pkg::state_t state_reg, state_next;
   logic [7:0]   rxBuf_reg [gw_pkg::RX_BUF_BYTES];
   logic [7:0]   rxBuf_next [gw_pkg::RX_BUF_BYTES];
   logic [4:0]   rxCnt_reg, rxCnt_next;
   logic [15:0]  rxCrc_reg, rxCrc_next, txCrc_reg, txCrc_next;
   logic [7:0]   idx_reg, idx_next;
   logic [3:0]   wReg_reg, wReg_next, fOff_reg, fOff_next;
   logic         hiLo_reg, hiLo_next, pend_reg, pend_next, drop_reg;
   logic [15:0]  txRegs_reg [gw_pkg::TX_WORDS];
   logic [15:0]  txRegs_next [gw_pkg::TX_WORDS];
   logic [111:0] frame_reg, frame_next;
   logic [15:0]  q_reg [gw_pkg::QUEUE_DEPTH][gw_pkg::FRAME_WORDS];
   logic [15:0]  q_next [gw_pkg::QUEUE_DEPTH][gw_pkg::FRAME_WORDS];
   logic [2:0]   rdPtr_reg, rdPtr_next, wrPtr_reg, wrPtr_next;
   logic [3:0]   occ_reg, occ_next, popN;
   logic         push, reqOk, isRead, commit;
   logic [7:0]   fn, respLen;
   logic [15:0]  start, qty, wordSel;

   // Bytewise CRC-16 with reflected polynomial
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ gw_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crcByte

   // ***************************************
   // Request decode
   // ***************************************
   assign fn      = rxBuf_reg[1];
   assign start   = {rxBuf_reg[2], rxBuf_reg[3]};
   assign qty     = {rxBuf_reg[4], rxBuf_reg[5]};
   assign isRead  = (fn == gw_pkg::FN_RD_HOLD) || (fn == gw_pkg::FN_RD_INPUT);
   assign respLen = isRead ? gw_pkg::READ_HDR_LEN + {qty[6:0], 1'b0} : gw_pkg::ECHO_LEN;

   // Accept only intact requests for this node with a served layout
   always_comb
   begin
      reqOk = (rxCrc_reg == 16'h0000) && (rxBuf_reg[0] == nodeId);
      unique case (fn)
         gw_pkg::FN_RD_HOLD:   reqOk = reqOk && rxCnt_reg == gw_pkg::LEN_SHORT
                                      && start == 16'h0000 && qty == gw_pkg::TX_QTY;
         gw_pkg::FN_RD_INPUT:  reqOk = reqOk && rxCnt_reg == gw_pkg::LEN_SHORT
                                      && start == 16'h0000 && qty != 16'h0000
                                      && qty <= gw_pkg::MAX_RD_QTY;
         gw_pkg::FN_WR_SINGLE: reqOk = reqOk && rxCnt_reg == gw_pkg::LEN_SHORT
                                      && start <= gw_pkg::TX_LAST_REG;
         gw_pkg::FN_WR_MULTI:  reqOk = reqOk && rxCnt_reg == gw_pkg::LEN_MULTI
                                      && start == 16'h0000 && qty == gw_pkg::TX_QTY
                                      && rxBuf_reg[6] == gw_pkg::TX_BYTE_CNT;
         default:              reqOk = 1'b0;
      endcase
   end

   // ***************************************
   // Response byte source
   // ***************************************
   always_comb
   begin
      wordSel = gw_pkg::ZERO_WORD;
      if (fn == gw_pkg::FN_RD_HOLD)
         wordSel = txRegs_reg[wReg_reg[2:0]];
      else if (fOff_reg < occ_reg)
         wordSel = q_reg[3'(rdPtr_reg + fOff_reg[2:0])][wReg_reg];
      txValid = 1'b0;
      txByte  = 8'h00;
      unique case (state_reg)
         gw_pkg::ST_SEND:
         begin
            txValid = 1'b1;
            if (!isRead || idx_reg < 8'h02)
               txByte = rxBuf_reg[idx_reg[4:0]];
            else if (idx_reg == 8'h02)
               txByte = {qty[6:0], 1'b0};
            else
               txByte = hiLo_reg ? wordSel[7:0] : wordSel[15:8];
         end
         gw_pkg::ST_CRC_LO:
         begin
            txValid = 1'b1;
            txByte  = txCrc_reg[7:0];
         end
         gw_pkg::ST_CRC_HI:
         begin
            txValid = 1'b1;
            txByte  = txCrc_reg[15:8];
         end
         default: ;
      endcase
   end

   // ***************************************
   // Request and response controller
   // ***************************************
   always_comb
   begin
      state_next  = state_reg;
      rxBuf_next  = rxBuf_reg;
      rxCnt_next  = rxCnt_reg;
      rxCrc_next  = rxCrc_reg;
      txCrc_next  = txCrc_reg;
      idx_next    = idx_reg;
      wReg_next   = wReg_reg;
      fOff_next   = fOff_reg;
      hiLo_next   = hiLo_reg;
      txRegs_next = txRegs_reg;
      frame_next  = frame_reg;
      commit      = 1'b0;
      popN        = 4'h0;
      unique case (state_reg)
         gw_pkg::ST_IDLE:
            if (rxEnd)
               state_next = gw_pkg::ST_CHECK;
            else if (rxValid)
            begin
               if (rxCnt_reg <= gw_pkg::RX_BUF_LAST)
               begin
                  rxBuf_next[rxCnt_reg] = rxByte;
                  rxCnt_next = rxCnt_reg + 5'h01;
               end
               rxCrc_next = crcByte(rxCrc_reg, rxByte);
            end
         gw_pkg::ST_CHECK:
         begin
            rxCnt_next = 5'h00;
            rxCrc_next = gw_pkg::CRC_INIT;
            state_next = reqOk ? gw_pkg::ST_SEND : gw_pkg::ST_IDLE;
            idx_next   = 8'h00;
            wReg_next  = 4'h0;
            fOff_next  = 4'h0;
            hiLo_next  = 1'b0;
            txCrc_next = gw_pkg::CRC_INIT;
            if (reqOk && fn == gw_pkg::FN_WR_SINGLE)
            begin
               txRegs_next[start[2:0]] = qty;
               commit = (start == gw_pkg::TX_LAST_REG);
            end
            if (reqOk && fn == gw_pkg::FN_WR_MULTI)
            begin
               for (int k = 0; k < gw_pkg::TX_WORDS; k++)
               begin
                  txRegs_next[k] = {rxBuf_reg[7 + 2 * k], rxBuf_reg[8 + 2 * k]};
               end
               commit = 1'b1;
            end
            if (commit)
            begin
               for (int k = 0; k < gw_pkg::TX_WORDS; k++)
               begin
                  frame_next[111 - 16 * k -: 16] = txRegs_next[k];
               end
            end
         end
         gw_pkg::ST_SEND:
            if (txReady)
            begin
               txCrc_next = crcByte(txCrc_reg, txByte);
               idx_next   = idx_reg + 8'h01;
               if (isRead && idx_reg > 8'h02)
               begin
                  hiLo_next = !hiLo_reg;
                  if (hiLo_reg && wReg_reg == gw_pkg::FRAME_LAST)
                  begin
                     wReg_next = 4'h0;
                     fOff_next = fOff_reg + 4'h1;
                  end
                  else if (hiLo_reg)
                     wReg_next = wReg_reg + 4'h1;
               end
               if (idx_next == respLen)
                  state_next = gw_pkg::ST_CRC_LO;
            end
         gw_pkg::ST_CRC_LO:
            if (txReady)
               state_next = gw_pkg::ST_CRC_HI;
         gw_pkg::ST_CRC_HI:
            if (txReady)
            begin
               state_next = gw_pkg::ST_IDLE;
               if (fn == gw_pkg::FN_RD_INPUT)
                  popN = (fOff_reg < occ_reg) ? fOff_reg : occ_reg;
            end
         default:
            state_next = gw_pkg::ST_IDLE;
      endcase
   end

   // Transmit buffer hand-off holds until the bus is idle
   assign canTxStart = pend_reg && canBusIdle;
   assign pend_next  = commit || (pend_reg && !canBusIdle);

   // ***************************************
   // CAN receive queue
   // ***************************************
   assign push = canRxValid && slaveMode && !canRxSpecific && occ_reg < gw_pkg::QUEUE_FULL;

   always_comb
   begin
      q_next     = q_reg;
      wrPtr_next = wrPtr_reg;
      rdPtr_next = 3'(rdPtr_reg + popN[2:0]);
      occ_next   = occ_reg - popN;
      if (push)
      begin
         for (int k = 0; k < gw_pkg::FRAME_WORDS; k++)
         begin
            q_next[wrPtr_reg][k] = canRxData[143 - 16 * k -: 16];
         end
         wrPtr_next = wrPtr_reg + 3'h1;
         occ_next   = occ_reg - popN + 4'h1;
      end
   end

   // Register all state
   always_ff @(posedge clk)
   begin
      rxBuf_reg  <= rxBuf_next;
      txRegs_reg <= txRegs_next;
      q_reg      <= q_next;
      if (rst)
      begin
         state_reg <= gw_pkg::ST_IDLE;
         rxCnt_reg <= 5'h00;
         rxCrc_reg <= gw_pkg::CRC_INIT;
         txCrc_reg <= gw_pkg::CRC_INIT;
         idx_reg   <= 8'h00;
         wReg_reg  <= 4'h0;
         fOff_reg  <= 4'h0;
         hiLo_reg  <= 1'b0;
         frame_reg <= '0;
         pend_reg  <= 1'b0;
         rdPtr_reg <= 3'h0;
         wrPtr_reg <= 3'h0;
         occ_reg   <= 4'h0;
         drop_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         rxCnt_reg <= rxCnt_next;
         rxCrc_reg <= rxCrc_next;
         txCrc_reg <= txCrc_next;
         idx_reg   <= idx_next;
         wReg_reg  <= wReg_next;
         fOff_reg  <= fOff_next;
         hiLo_reg  <= hiLo_next;
         frame_reg <= frame_next;
         pend_reg  <= pend_next;
         rdPtr_reg <= rdPtr_next;
         wrPtr_reg <= wrPtr_next;
         occ_reg   <= occ_next;
         drop_reg  <= canRxValid && slaveMode && !canRxSpecific && !push;
      end
   end

   assign canTxFrame   = frame_reg;
   assign canTxPending = pend_reg;
   assign queueDrop    = drop_reg;

   // ***************************************
   // Checks
   // ***************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   queue_push_a: assert property (push && popN == 4'h0 |=> occ_reg == $past(occ_reg) + 4'h1)
      else $error("accepted CAN frame not queued");
   specific_skip_a: assert property (canRxSpecific && popN == 4'h0 |=> occ_reg == $past(occ_reg))
      else $error("specific frame entered queue");
   input_read_a: assert property (state_reg == gw_pkg::ST_CHECK && reqOk && fn == gw_pkg::FN_RD_INPUT
      |=> txValid && txByte == nodeId)
      else $error("read-input request not answered");
   byte_count_a: assert property (state_reg == gw_pkg::ST_SEND && isRead && idx_reg == 8'h02
      |-> txByte == 8'(qty * 2))
      else $error("wrong response byte count");
   queue_pop_a: assert property (state_reg == gw_pkg::ST_CRC_HI && txReady && fn == gw_pkg::FN_RD_INPUT
      && !push && fOff_reg <= occ_reg |=> occ_reg == $past(occ_reg) - $past(fOff_reg))
      else $error("read frames not removed");
   tx_commit_a: assert property (state_reg == gw_pkg::ST_CHECK && reqOk && fn == gw_pkg::FN_WR_MULTI
      |=> canTxPending && canTxFrame[111:104] == $past(rxBuf_reg[7]))
      else $error("transmit record not buffered");
   tx_start_a: assert property (canTxPending && canBusIdle && state_reg != gw_pkg::ST_CHECK
      |-> canTxStart ##1 !canTxPending)
      else $error("idle bus did not start transmit");
   hold_count_a: assert property (state_reg == gw_pkg::ST_SEND && fn == gw_pkg::FN_RD_HOLD
      && idx_reg == 8'h02 |-> txByte == gw_pkg::HOLD_BYTES)
      else $error("holding read length wrong");
   echo_a: assert property (state_reg == gw_pkg::ST_SEND && fn == gw_pkg::FN_WR_SINGLE
      |-> txByte == rxBuf_reg[idx_reg[4:0]])
      else $error("single write not echoed");
   reject_a: assert property (state_reg == gw_pkg::ST_CHECK && !reqOk
      |=> !txValid [*2])
      else $error("bad request answered");
   zero_fill_a: assert property (state_reg == gw_pkg::ST_SEND && fn == gw_pkg::FN_RD_INPUT
      && idx_reg > 8'h02 && fOff_reg >= occ_reg |-> txByte == 8'h00)
      else $error("empty slot not zero");
endmodule : modbus_can_gateway

/* serial_master_model.sv */
// Serial master stand-in that takes response bytes with random stalls
`timescale 1ns/1ps
module serial_master_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Response bytes
   input  wire logic [7:0] txByte,
   input  wire logic       txValid,
   output logic            txReady
);
   // ***********************************************
   // Stalling byte sink
   // ***********************************************
   logic [7:0] got[$];
   int         seed = 11;

   initial txReady = 1'b0;

   // Stalls show whether each byte stands until it is taken
   always @(posedge clk)
   begin
      if (!rst && txValid && txReady)
         got.push_back(txByte);
      txReady <= ($random(seed) & 3) != 0;
   end
endmodule : serial_master_model

/* tb_top.sv */
// Self-checking bench for the serial-to-CAN message gateway
`timescale 1ns/1ps
module tb_top;
   // ***********************************************
   // Signals, instances and clock
   // ***********************************************
   logic         clk, rst, slaveMode, rxValid, rxEnd, txValid, txReady, queueDrop;
   logic         canRxValid, canRxSpecific, canTxPending, canTxStart, canBusIdle;
   logic [7:0]   nodeId, rxByte, txByte;
   logic [143:0] canRxData;
   logic [111:0] canTxFrame, txRec;
   logic [143:0] pend[$];                 // Frames expected in the queue
   logic [7:0]   req[$], exp[$];
   int           err_count = 0, checks_done = 0, seed = 11;

   modbus_can_gateway uut (.clk(clk), .rst(rst), .slaveMode(slaveMode), .nodeId(nodeId),
      .rxByte(rxByte), .rxValid(rxValid), .rxEnd(rxEnd), .txByte(txByte), .txValid(txValid),
      .txReady(txReady), .canRxData(canRxData), .canRxValid(canRxValid),
      .canRxSpecific(canRxSpecific), .queueDrop(queueDrop), .canTxFrame(canTxFrame),
      .canTxPending(canTxPending), .canTxStart(canTxStart), .canBusIdle(canBusIdle));
   serial_master_model master (.clk(clk), .rst(rst), .txByte(txByte), .txValid(txValid),
      .txReady(txReady));

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Random bits for frames and records
   function automatic logic [159:0] rnd();
      return {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
   endfunction : rnd

   // Request checksum, low byte sent first
   task automatic add_crc(ref logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i])
      begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endtask : add_crc

   // Compare tasks
   task automatic chk_resp(string what);
      int at;
      at = -1;
      if (master.got.size() == exp.size())
      begin
         foreach (exp[i])
         begin
            if (at < 0 && master.got[i] !== exp[i])
               at = i;
         end
      end
      checks_done++;
      if (master.got.size() != exp.size())
      begin
         err_count++;
         $display("Error %s size: expected %0d seen %0d", what, exp.size(), master.got.size());
      end
      else if (at >= 0)
      begin
         err_count++;
         $display("Error %s byte %0d: expected %h seen %h", what, at, exp[at], master.got[at]);
      end
   endtask : chk_resp

   task automatic chk_sig(string what, logic [111:0] e, logic [111:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s: expected %h seen %h", what, e, g);
      end
   endtask : chk_sig

   // Send a request, collect the reply and compare it
   task automatic run(string what, bit badCrc);
      add_crc(req);
      if (badCrc)
         req[req.size() - 1] ^= 8'h01;
      if (exp.size() > 0)
         add_crc(exp);
      foreach (req[i])
      begin
         @(posedge clk);
         rxByte  <= req[i];
         rxValid <= 1'b1;
         @(posedge clk);
         rxValid <= 1'b0;
      end
      @(posedge clk);
      rxEnd <= 1'b1;
      @(posedge clk);
      rxEnd <= 1'b0;
      for (int i = 0; i < 3000 && master.got.size() < exp.size(); i++)
         @(posedge clk);
      repeat (20) @(posedge clk);
      chk_resp(what);
      master.got.delete();
   endtask : run

   // Offer one CAN frame and model whether it is queued or lost
   task automatic push_can(logic spec);
      logic [159:0] r;
      logic         take;
      r = rnd();
      @(posedge clk);
      take          = slaveMode && !spec;
      canRxData     <= r[143:0];
      canRxSpecific <= spec;
      canRxValid    <= 1'b1;
      @(posedge clk);
      canRxValid <= 1'b0;
      #1 chk_sig("queueDrop", {111'h0, take && pend.size() == 8}, {111'h0, queueDrop});
      if (take && pend.size() < 8)
         pend.push_back(r[143:0]);
   endtask : push_can

   // Read whole nine-word slots from the receive window
   task automatic read_input(int slots);
      logic [143:0] f;
      logic [7:0]   q;
      q   = 8'(9 * slots);
      req = {nodeId, gw_pkg::FN_RD_INPUT, 8'h00, 8'h00, 8'h00, q};
      exp = {nodeId, gw_pkg::FN_RD_INPUT, 8'(2 * q)};
      for (int s = 0; s < slots; s++)
      begin
         f = s < pend.size() ? pend[s] : 144'h0;
         for (int b = 0; b < 18; b++) exp.push_back(f[143 - 8 * b -: 8]);
      end
      for (int s = 0; s < slots && pend.size() > 0; s++) void'(pend.pop_front());
      run("read input response", 1'b0);
   endtask : read_input

   // Transmit record writes and read-back
   task automatic write_multi(logic [111:0] rec);
      req = {nodeId, gw_pkg::FN_WR_MULTI, 8'h00, 8'h00, 8'h00, 8'h07, 8'h0D};
      for (int b = 0; b < 14; b++) req.push_back(rec[111 - 8 * b -: 8]);
      exp = req[0:5];
      run("write multiple echo", 1'b0);
   endtask : write_multi

   task automatic write_single(logic [7:0] idx, logic [15:0] w);
      req = {nodeId, gw_pkg::FN_WR_SINGLE, 8'h00, idx, w[15:8], w[7:0]};
      exp = req;
      run("write single echo", 1'b0);
   endtask : write_single

   task automatic read_hold(logic [111:0] rec);
      req = {nodeId, gw_pkg::FN_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'h07};
      exp = {nodeId, gw_pkg::FN_RD_HOLD, gw_pkg::HOLD_BYTES};
      for (int b = 0; b < 14; b++) exp.push_back(rec[111 - 8 * b -: 8]);
      run("read holding response", 1'b0);
   endtask : read_hold

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // Cut a hung run short
   initial
   begin
      #400000;
      err_count++;
      tally_and_finish();
   end

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial
   begin
      logic [159:0] r;
      rst           = 1'b1;
      slaveMode     = 1'b1;
      nodeId        = 8'h11;
      rxByte        = 8'h00;
      rxValid       = 1'b0;
      rxEnd         = 1'b0;
      canRxData     = 144'h0;
      canRxValid    = 1'b0;
      canRxSpecific = 1'b0;
      canBusIdle    = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // Specific frames and frames outside slave mode are skipped
      push_can(1'b0);
      push_can(1'b1);
      push_can(1'b0);
      @(posedge clk);
      slaveMode <= 1'b0;
      push_can(1'b0);
      @(posedge clk);
      slaveMode <= 1'b1;
      push_can(1'b0);
      read_input(2);
      read_input(2);
      read_input(1);
      // Bad checksum and foreign node get no reply and pop nothing
      push_can(1'b0);
      req = {nodeId, gw_pkg::FN_RD_INPUT, 8'h00, 8'h00, 8'h00, 8'h09};
      exp.delete();
      run("bad checksum", 1'b1);
      req = {8'(nodeId + 8'h01), gw_pkg::FN_RD_INPUT, 8'h00, 8'h00, 8'h00, 8'h09};
      run("foreign node", 1'b0);
      read_input(1);
      // Full queue drops the ninth frame
      repeat (9) push_can(1'b0);
      read_input(8);
      // Random traffic and read sizes
      repeat (4)
      begin
         repeat ($random(seed) & 3) push_can(1'($random(seed)));
         read_input(1 + ($random(seed) & 3));
      end
      // Transmit record by multiple and by single writes
      r     = rnd();
      txRec = r[111:0];
      write_multi(txRec);
      chk_sig("canTxPending", 112'h1, {111'h0, canTxPending});
      chk_sig("canTxFrame", txRec, canTxFrame);
      read_hold(txRec);
      r     = rnd();
      txRec = r[111:0];
      for (int i = 0; i < 7; i++) write_single(8'(i), txRec[111 - 16 * i -: 16]);
      chk_sig("canTxFrame", txRec, canTxFrame);
      read_hold(txRec);
      // Frame starts once the bus is idle
      @(posedge clk);
      canBusIdle <= 1'b1;
      #1 chk_sig("canTxStart", 112'h1, {111'h0, canTxStart});
      @(posedge clk);
      canBusIdle <= 1'b0;
      #1 chk_sig("canTxPending", 112'h0, {111'h0, canTxPending});
      tally_and_finish();
   end
endmodule : tb_top
